// File: rtl/rtcl_consts.vh
// constants for the reset timeout and cause logic
`ifndef RTCL_CONSTS_VH
`define RTCL_CONSTS_VH

// register byte offsets
`define RTCL_OFS_CAUSE 8'h00
`define RTCL_OFS_STATUS 8'h04
`define RTCL_OFS_CONFIG 8'h08
`define RTCL_OFS_STATE 8'h0C

// cause register fields
`define RTCL_CAUSE_BROWNOUT 0
`define RTCL_CAUSE_POWERON 1

// status register fields
`define RTCL_ST_POWERDOWN 3
`define RTCL_ST_TIMEOUT 4

// config register fields
`define RTCL_CFG_RC_MODE 0
`define RTCL_CFG_POWER_UP_TIMER_EN_N 1
`define RTCL_CFG_BOD_EN 2
`define RTCL_CONFIG_RESET 3'h2

// reset values
`define RTCL_STATUS_RESET 8'h18
`define RTCL_CAUSE_RESET 2'h0

// program counter targets
`define RTCL_PC_RESET 13'h0000
`define RTCL_PC_VECTOR 13'h0004

// timing
`define RTCL_CLK_PERIOD_NS 4
`define RTCL_POWER_UP_TIMER_TIME_MS 72
`define RTCL_POWER_UP_TIMER_CYCLES ((`RTCL_POWER_UP_TIMER_TIME_MS * 1000000 + `RTCL_CLK_PERIOD_NS - 1) / `RTCL_CLK_PERIOD_NS)
`define RTCL_OST_PERIODS 1024
`define RTCL_POR_DELAY_CYCLES 16

// bus responses
`define RTCL_RESP_OKAY 2'h0
`define RTCL_RESP_SLVERR 2'h2

`endif

// File: rtl/rtcl_top.v
// reset timeout sequencer and reset cause flags with an axi4-lite register port
`timescale 1ns/100ps
`default_nettype none
`include "rtcl_consts.vh"

module rtcl_top #(
  parameter POWER_UP_TIMER_CYCLES = `RTCL_POWER_UP_TIMER_CYCLES,
  parameter OST_PERIODS = `RTCL_OST_PERIODS,
  parameter POR_DELAY_CYCLES = `RTCL_POR_DELAY_CYCLES,
  parameter CNT_W = 25,
  parameter PC_W = 13
) (
  // clock and bus reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // reset and wake sources
  input wire power_on_pulse,
  input wire master_clear_n,
  input wire brownout_detect,
  input wire watchdog_timer_expired,
  input wire sleep_enter,
  input wire interrupt_wake,
  input wire global_interrupt_enable,
  input wire osc_tick,
  // core side
  input wire [PC_W-1:0] core_pc,
  output reg core_run,
  output reg pc_load,
  output reg [PC_W-1:0] pc_load_addr,
  output reg [7:0] status_out
);

  // one-hot sequencer states
  localparam [5:0] ST_RUN = 6'h01;
  localparam [5:0] ST_PORD = 6'h02;
  localparam [5:0] ST_POWER_UP_TIMER = 6'h04;
  localparam [5:0] ST_OST = 6'h08;
  localparam [5:0] ST_HOLD = 6'h10;
  localparam [5:0] ST_SLEEP = 6'h20;

  // pending program counter target kinds
  localparam [1:0] PK_ZERO = 2'h0;
  localparam [1:0] PK_NEXT = 2'h1;
  localparam [1:0] PK_VECTOR = 2'h2;

  reg [5:0] state; // sequencer state
  reg [CNT_W-1:0] cnt; // delay counter, cycles or oscillator periods
  reg [1:0] pend_kind; // where execution resumes after the delay
  reg [1:0] cause; // power-on and brown-out flags
  reg [2:0] config_bits; // oscillator mode, timer enable, brown-out enable
  reg master_clear_n_q; // master clear sampled last cycle
  reg [7:0] aw_addr; // held write address
  reg [31:0] w_data; // held write data
  reg [3:0] w_strb; // held write strobes
  reg aw_got; // write address captured
  reg w_got; // write data captured

  wire rc_mode = config_bits[`RTCL_CFG_RC_MODE];
  wire power_up_timer_en_n = config_bits[`RTCL_CFG_POWER_UP_TIMER_EN_N];
  wire bod_en = config_bits[`RTCL_CFG_BOD_EN];
  wire master_clear_n_fall = master_clear_n_q & ~master_clear_n; // new master clear
  wire bor_evt = brownout_detect & bod_en; // brown-out only when enabled
  wire wr_go = aw_got & w_got & ~bvalid; // both halves present
  wire wr_lane0 = wr_go & w_strb[0]; // low byte carries every field

  // write path: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RTCL_RESP_OKAY;
    end else begin
      // capture address
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      // capture data
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      // perform the write and answer
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        case (aw_addr)
          `RTCL_OFS_CAUSE, `RTCL_OFS_STATUS, `RTCL_OFS_CONFIG: bresp <= `RTCL_RESP_OKAY;
          default: bresp <= `RTCL_RESP_SLVERR;
        endcase
      end
      // response taken, reopen both channels
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read path: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RTCL_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RTCL_RESP_OKAY;
        case (araddr)
          `RTCL_OFS_CAUSE: rdata <= {30'h0, cause};
          `RTCL_OFS_STATUS: rdata <= {24'h0, status_out};
          `RTCL_OFS_CONFIG: rdata <= {29'h0, config_bits};
          `RTCL_OFS_STATE: rdata <= {23'h0, core_run, pend_kind, state};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RTCL_RESP_SLVERR;
          end
        endcase
      end
      // data taken
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // configuration register, written only by software
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_bits <= `RTCL_CONFIG_RESET;
    end else if (wr_lane0 && aw_addr == `RTCL_OFS_CONFIG) begin
      config_bits <= w_data[2:0];
    end
  end

  // master clear edge history
  always @(posedge aclk) begin
    if (!aresetn) begin
      master_clear_n_q <= 1'b1;
    end else begin
      master_clear_n_q <= master_clear_n;
    end
  end

  // cause flags: software write first, reset events override after
  always @(posedge aclk) begin
    if (!aresetn) begin
      cause <= `RTCL_CAUSE_RESET;
    end else begin
      if (wr_lane0 && aw_addr == `RTCL_OFS_CAUSE) begin
        cause <= w_data[1:0];
      end
      if (power_on_pulse) begin
        cause[`RTCL_CAUSE_POWERON] <= 1'b0;
        if (bod_en) begin
          cause[`RTCL_CAUSE_BROWNOUT] <= 1'b1;
        end
      end else if (bor_evt) begin
        cause[`RTCL_CAUSE_BROWNOUT] <= 1'b0;
      end
    end
  end

  // core status register; timeout and power-down owned by hardware
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_out <= `RTCL_STATUS_RESET;
    end else begin
      if (wr_lane0 && aw_addr == `RTCL_OFS_STATUS) begin
        status_out[7:5] <= w_data[7:5];
        status_out[2:0] <= w_data[2:0];
      end
      if (power_on_pulse) begin
        status_out[7:3] <= 5'h03;
      end else if (bor_evt) begin
        status_out[7:3] <= 5'h03;
      end else if (master_clear_n_fall && state == ST_SLEEP) begin
        status_out[7:3] <= 5'h02; // timeout set, power-down clear
      end else if (master_clear_n_fall && state == ST_RUN) begin
        status_out[7:5] <= 3'h0;
      end else if (watchdog_timer_expired && state == ST_RUN) begin
        status_out[7:3] <= 5'h01;
      end else if (watchdog_timer_expired && state == ST_SLEEP) begin
        status_out[`RTCL_ST_TIMEOUT] <= 1'b0;
        status_out[`RTCL_ST_POWERDOWN] <= 1'b0;
      end else if (interrupt_wake && state == ST_SLEEP) begin
        status_out[`RTCL_ST_TIMEOUT] <= 1'b1;
        status_out[`RTCL_ST_POWERDOWN] <= 1'b0;
      end else if (sleep_enter && state == ST_RUN) begin
        status_out[`RTCL_ST_TIMEOUT] <= 1'b1;
        status_out[`RTCL_ST_POWERDOWN] <= 1'b0;
      end
    end
  end

  // sequencer: delays, hold under master clear, program counter load
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_HOLD;
      cnt <= {CNT_W{1'b0}};
      pend_kind <= PK_ZERO;
      core_run <= 1'b0;
      pc_load <= 1'b0;
      pc_load_addr <= `RTCL_PC_RESET;
    end else begin
      pc_load <= 1'b0;
      if (power_on_pulse) begin
        // power-up: no delay at all for rc mode without the timer
        cnt <= {CNT_W{1'b0}};
        pend_kind <= PK_ZERO;
        core_run <= 1'b0;
        if (rc_mode && power_up_timer_en_n) begin
          state <= ST_HOLD;
        end else begin
          state <= ST_PORD;
        end
      end else if (bor_evt) begin
        // brown-out always runs the 72 ms timer
        cnt <= {CNT_W{1'b0}};
        pend_kind <= PK_ZERO;
        core_run <= 1'b0;
        state <= ST_POWER_UP_TIMER;
      end else begin
        case (state)
          ST_RUN: begin
            if (!master_clear_n || watchdog_timer_expired) begin
              pend_kind <= PK_ZERO;
              core_run <= 1'b0;
              state <= ST_HOLD;
            end else if (sleep_enter) begin
              core_run <= 1'b0;
              state <= ST_SLEEP;
            end
          end
          ST_PORD: begin
            // master clear is not looked at while delays run
            cnt <= cnt + 1'b1;
            if (cnt >= POR_DELAY_CYCLES - 1) begin
              cnt <= {CNT_W{1'b0}};
              if (!power_up_timer_en_n) begin
                state <= ST_POWER_UP_TIMER;
              end else if (rc_mode) begin
                state <= ST_HOLD;
              end else begin
                state <= ST_OST;
              end
            end
          end
          ST_POWER_UP_TIMER: begin
            cnt <= cnt + 1'b1;
            if (cnt >= POWER_UP_TIMER_CYCLES - 1) begin
              cnt <= {CNT_W{1'b0}};
              state <= rc_mode ? ST_HOLD : ST_OST;
            end
          end
          ST_OST: begin
            // counts oscillator periods, not bus clocks
            if (osc_tick) begin
              cnt <= cnt + 1'b1;
              if (cnt >= OST_PERIODS - 1) begin
                cnt <= {CNT_W{1'b0}};
                state <= ST_HOLD;
              end
            end
          end
          ST_HOLD: begin
            // release as soon as master clear is high
            if (master_clear_n) begin
              state <= ST_RUN;
              core_run <= 1'b1;
              pc_load <= 1'b1;
              case (pend_kind)
                PK_NEXT: pc_load_addr <= core_pc + 1'b1;
                PK_VECTOR: pc_load_addr <= `RTCL_PC_VECTOR;
                default: pc_load_addr <= `RTCL_PC_RESET;
              endcase
            end
          end
          ST_SLEEP: begin
            if (!master_clear_n) begin
              pend_kind <= PK_ZERO;
              state <= ST_HOLD;
            end else if (watchdog_timer_expired || interrupt_wake) begin
              cnt <= {CNT_W{1'b0}};
              if (interrupt_wake && !watchdog_timer_expired && global_interrupt_enable) begin
                pend_kind <= PK_VECTOR;
              end else begin
                pend_kind <= PK_NEXT;
              end
              state <= rc_mode ? ST_HOLD : ST_OST;
            end
          end
          default: begin
            state <= ST_HOLD;
            core_run <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/rtcl_top_properties.sv
// concurrent checks on the reset sequencer ports
`timescale 1ns/100ps
`default_nettype none
module rtcl_checker #(
  parameter PC_W = 13
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshake outputs
  input wire logic awready,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic rvalid,
  // reset and wake sources
  input wire logic power_on_pulse,
  input wire logic master_clear_n,
  input wire logic brownout_detect,
  input wire logic watchdog_timer_expired,
  // core side
  input wire logic core_run,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_addr,
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  load_one_cycle_a: assert property (pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  run_after_load_a: assert property (pc_load |-> core_run)
    else $error("core not running after pc load");
  poweron_stops_a: assert property (power_on_pulse |=> !core_run)
    else $error("core runs during power-on");
  poweron_status_a: assert property (power_on_pulse |=> status_out[7:3] == 5'h03)
    else $error("power-on status bits wrong");
  clear_holds_a: assert property (!master_clear_n ##1 !master_clear_n |-> !core_run && !pc_load)
    else $error("core runs under master clear");
  clear_status_a: assert property ($fell(master_clear_n) && core_run |-> ##[1:2] status_out[7:5] == 3'h0)
    else $error("master clear status upper bits not cleared");
  reset_pc_zero_a: assert property (pc_load && status_out[3] |-> pc_load_addr == '0)
    else $error("reset load address not zero");
  watchdog_flags_a: assert property (watchdog_timer_expired && core_run && master_clear_n &&
      !power_on_pulse && !brownout_detect |=> status_out[4:3] == 2'h1)
    else $error("watchdog reset flags wrong");
  bus_reset_a: assert property ($rose(aresetn) |-> status_out == 8'h18 && awready && arready && !bvalid && !rvalid)
    else $error("reset values wrong");
  // main scenarios
  cover property (power_on_pulse ##[1:200] pc_load);
  cover property (pc_load && pc_load_addr == 'h4);
  cover property (watchdog_timer_expired && core_run);
endmodule
bind rtcl_top rtcl_checker #(.PC_W(PC_W)) i_chk (.aclk(aclk), .aresetn(aresetn), .awready(awready),
  .arready(arready), .bvalid(bvalid), .rvalid(rvalid), .power_on_pulse(power_on_pulse),
  .master_clear_n(master_clear_n), .brownout_detect(brownout_detect),
  .watchdog_timer_expired(watchdog_timer_expired),
  .core_run(core_run), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .status_out(status_out));
`default_nettype wire

// File: testbench/rtcl_top_bench.sv
// self-checking bench for the reset sequencer and its register port
`timescale 1ns/100ps
`default_nettype none
`include "rtcl_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module rtcl_top_bench;
  localparam P_CYC = 50; // shortened power-up timer
  localparam D_CYC = 4; // shortened power-on delay
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic power_on_pulse = 1'h0, master_clear_n = 1'h1, brownout_detect = 1'h0;
  logic watchdog_timer_expired = 1'h0, sleep_enter = 1'h0, interrupt_wake = 1'h0;
  logic global_interrupt_enable = 1'h0, osc_tick = 1'h0;
  logic [12:0] core_pc = 13'h0123; // held so the wake address is known
  wire core_run, pc_load;
  wire [12:0] pc_load_addr;
  wire [7:0] status_out;
  logic [1:0] tick_div = '0, r, b;
  int err_total = 0, check_count = 0, n;
  rtcl_top #(.POWER_UP_TIMER_CYCLES(P_CYC), .OST_PERIODS(8), .POR_DELAY_CYCLES(D_CYC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .power_on_pulse(power_on_pulse), .master_clear_n(master_clear_n),
    .brownout_detect(brownout_detect), .watchdog_timer_expired(watchdog_timer_expired),
    .sleep_enter(sleep_enter), .interrupt_wake(interrupt_wake),
    .global_interrupt_enable(global_interrupt_enable), .osc_tick(osc_tick),
    .core_pc(core_pc), .core_run(core_run), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .status_out(status_out));
  // 4 ns clock
  initial forever #2 aclk = ~aclk;
  // oscillator period of four clocks
  always @(posedge aclk) begin
    tick_div <= tick_div + 2'h1;
    osc_tick <= (tick_div == 2'h3);
  end
  // verdict and end of run
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit dn = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 40 && !dn; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        bready <= 1'h0;
        b = bresp;
        dn = 1;
      end
    end
    if (!dn) begin err_total++; stop_test; end
  endtask
  // one read, data and response kept in d and r
  task automatic rd(input logic [7:0] a);
    bit dn = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 40 && !dn; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rready <= 1'h0;
        d = rdata;
        r = rresp;
        dn = 1;
      end
    end
    if (!dn) begin err_total++; stop_test; end
  endtask
  // one-cycle pulse on the selected event inputs
  task automatic go(input logic [4:0] s);
    @(posedge aclk);
    {power_on_pulse, brownout_detect, watchdog_timer_expired, sleep_enter, interrupt_wake} <= s;
    @(posedge aclk);
    {power_on_pulse, brownout_detect, watchdog_timer_expired, sleep_enter, interrupt_wake} <= '0;
  endtask
  // wait for the pc load strobe, cycles counted in n
  task automatic wait_load(input int mx);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pc_load !== 1'h1 && n < mx);
    if (pc_load !== 1'h1) begin err_total++; stop_test; end
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK("status_rst", `RTCL_STATUS_RESET, status_out)
    rd(`RTCL_OFS_CONFIG);
    `CHK("cfg_rst", 32'h2, d)
    rd(8'h10);
    `CHK("unmapped_resp", `RTCL_RESP_SLVERR, r)
    wr(`RTCL_OFS_STATE, 32'h0);
    `CHK("ro_wr_resp", `RTCL_RESP_SLVERR, b)
    // power-on, crystal, timer on, brown-out detect on
    wr(`RTCL_OFS_CONFIG, 32'h4);
    `CHK("wr_resp", `RTCL_RESP_OKAY, b)
    go(5'h10);
    wait_load(200);
    `CHK("po_time", 1'h1, n >= D_CYC + P_CYC + 26 && n <= D_CYC + P_CYC + 40)
    `CHK("po_addr", `RTCL_PC_RESET, pc_load_addr)
    `CHK("po_status", 5'h03, status_out[7:3])
    rd(`RTCL_OFS_STATE);
    `CHK("po_state", 32'h101, d)
    rd(`RTCL_OFS_CAUSE);
    `CHK("po_cause", 32'h1, d)
    wr(`RTCL_OFS_CAUSE, 32'h3);
    rd(`RTCL_OFS_CAUSE);
    `CHK("sw_cause", 32'h3, d)
    go(5'h08);
    wait_load(200);
    `CHK("bo_time", 1'h1, n >= P_CYC + 26 && n <= P_CYC + 40)
    rd(`RTCL_OFS_CAUSE);
    `CHK("bo_cause", 32'h2, d)
    go(5'h04);
    wait_load(4);
    `CHK("wdt_flags", 2'h1, status_out[4:3])
    `CHK("wdt_addr", `RTCL_PC_RESET, pc_load_addr)
    go(5'h02);
    @(posedge aclk);
    `CHK("sleep_run", 1'h0, core_run)
    `CHK("sleep_flags", 2'h2, status_out[4:3])
    go(5'h04);
    wait_load(60);
    `CHK("wake_time", 1'h1, n >= 26 && n <= 40)
    `CHK("wake_addr", 13'h0124, pc_load_addr)
    `CHK("wake_flags", 2'h0, status_out[4:3])
    global_interrupt_enable <= 1'h1;
    go(5'h02);
    go(5'h01);
    wait_load(60);
    `CHK("irq_addr", `RTCL_PC_VECTOR, pc_load_addr)
    wr(`RTCL_OFS_STATUS, 32'hFF);
    `CHK("st_write", 8'hF7, status_out)
    master_clear_n <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK("master_clear_n_status", 8'h17, status_out)
    rd(`RTCL_OFS_CAUSE);
    `CHK("master_clear_n_cause", 32'h2, d)
    master_clear_n <= 1'h1;
    wait_load(4);
    // rc mode, timer off, master clear held through power-on
    wr(`RTCL_OFS_CONFIG, 32'h3);
    master_clear_n <= 1'h0;
    go(5'h10);
    repeat (20) @(posedge aclk);
    `CHK("rc_hold", 1'h0, core_run)
    master_clear_n <= 1'h1;
    wait_load(4);
    `CHK("rc_addr", `RTCL_PC_RESET, pc_load_addr)
    rd(`RTCL_OFS_CAUSE);
    `CHK("rc_poweron", 1'h0, d[1])
    // rc mode, timer off, master clear high: load follows at once
    go(5'h10);
    wait_load(4);
    `CHK("rc_nodelay", 2, n)
    // rc mode with the timer: power-on delay and timer, no oscillator wait
    wr(`RTCL_OFS_CONFIG, 32'h1);
    go(5'h10);
    wait_load(200);
    `CHK("rc_timer", 1'h1, n >= D_CYC + P_CYC && n <= D_CYC + P_CYC + 4)
    stop_test;
  end
endmodule
`default_nettype wire
